// *** rtl/backplane_phy_seq_fec_an_csr.v ***
// Summary of operation
// - Sequencer restart pulses reset, then self-clears
// - Link ready status follows sequencer
// - Negotiation timeout latched until negotiation restarts
// - Training timeout shown as read-only status
// - Six-bit one-hot reconfiguration mode readback
// - FEC capability and error-report capability readback
// - Transcoder and encoder injection enable bits
// - Four-bit error burst length field
// - Inject bit pulses error only while an injection enable bit is set, software clears it
// - Corrected counter saturates, clears on read
// - Uncorrectable counter saturates, clears on read
// - Negotiation enable, resets to one
// - User base page select steers transmitter
// - User next page select steers next pages
// - Local remote fault shown read-only
// - Nonce forcing bit drives transmitter
// - Override enable bit drives its own output, gates no other field
// - Negotiation reset pulses, self-clears
// - TX restart pulses only in negotiation state
// - Next page ready self-clears when page taken
// - Page arrived sticky, clears on read
// - Negotiation done status readback
`timescale 1ns/1ns
`include "kr_csr_defs.vh"
module backplane_phy_seq_fec_an_csr (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    // Management port
    input  wire [7:0]  i_mgmt_address,
    input  wire        i_mgmt_read,
    input  wire        i_mgmt_write,
    input  wire [31:0] i_mgmt_writedata,
    output reg  [31:0] o_mgmt_readdata,
    output reg         o_mgmt_readdatavalid,
    // Sequencer
    input  wire        i_seq_link_ready,
    input  wire        i_seq_neg_timeout,
    input  wire        i_seq_neg_restart,
    input  wire        i_seq_trn_timeout,
    input  wire [5:0]  i_seq_mode,
    output reg         o_seq_restart,
    output reg         o_fec_ability,
    output reg         o_fec_error_indicate,
    output reg         o_fec_request_flag,
    // FEC
    input  wire        i_fec_supported,
    input  wire        i_fec_errind_supported,
    input  wire        i_fec_corrected,
    input  wire        i_fec_uncorrectable,
    output reg         o_transcoder_error_enable,
    output reg         o_encoder_burst_enable,
    output reg  [3:0]  o_error_burst_length,
    output reg         o_error_inject_pulse,
    // Negotiation
    input  wire        i_neg_tx_in_an_state,
    input  wire        i_neg_local_fault,
    input  wire        i_neg_page_arrived,
    input  wire        i_neg_done,
    input  wire        i_next_page_taken,
    output reg         o_neg_enable,
    output reg         o_user_base_page_select,
    output reg         o_user_next_page_select,
    output reg         o_force_nonce,
    output reg         o_negotiation_override_enable,
    output reg         o_negotiation_reset,
    output reg         o_negotiation_tx_restart,
    output reg         o_next_page_ready
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
wire [13:0] async_in = {i_seq_link_ready,
                        i_seq_neg_timeout,
                        i_seq_neg_restart,
                        i_seq_trn_timeout,
                        i_seq_mode,
                        i_neg_tx_in_an_state,
                        i_neg_local_fault,
                        i_neg_done,
                        i_fec_supported};
wire [13:0] status_s;

sync_2ff #(
    .WIDTH (14)
) u_sync_status (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   (async_in),
    .o_sync    (status_s)
);

wire       link_ready_s = status_s[13];
wire       neg_tmo_s    = status_s[12];
wire       neg_rst_s    = status_s[11];
wire       trn_tmo_s    = status_s[10];
wire [5:0] mode_s       = status_s[9:4];
wire       in_an_s      = status_s[3];
wire       local_rf_s   = status_s[2];
wire       neg_done_s   = status_s[1];
wire       fec_sup_s    = status_s[0];

////////////////////////////////////////////////////////////////////////////////
// Event and capability synchronisers
wire [1:0] events_s;
wire [1:0] aux_s;
reg  [1:0] ev3_q;

sync_2ff #(
    .WIDTH (2)
) u_sync_events (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_fec_corrected, i_fec_uncorrectable}),
    .o_sync    (events_s)
);

sync_2ff #(
    .WIDTH (2)
) u_sync_aux (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_neg_page_arrived, i_fec_errind_supported}),
    .o_sync    (aux_s)
);

// Previous event levels for edge detection
always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        ev3_q <= 2'h0;
    end else begin
        ev3_q <= events_s;
    end
end

wire       corr_ev      = events_s[1] & ~ev3_q[1];
wire       uncorr_ev    = events_s[0] & ~ev3_q[0];
wire       page_lvl_s   = aux_s[1];
wire       errind_sup_s = aux_s[0];
reg        page_prev_q;
wire       page_ev      = page_lvl_s & ~page_prev_q;

////////////////////////////////////////////////////////////////////////////////
// Decode
wire wr_seq_ctrl = i_mgmt_write && (i_mgmt_address == `ADDR_SEQ_CTRL);
wire wr_fec_inj  = i_mgmt_write && (i_mgmt_address == `ADDR_FEC_INJ);
wire wr_neg_ctrl = i_mgmt_write && (i_mgmt_address == `ADDR_NEG_CTRL);
wire wr_neg_cmd  = i_mgmt_write && (i_mgmt_address == `ADDR_NEG_CMD);
wire rd_corr     = i_mgmt_read && (i_mgmt_address == `ADDR_FEC_CORR);
wire rd_uncorr   = i_mgmt_read && (i_mgmt_address == `ADDR_FEC_UNCORR);
wire rd_neg_stat = i_mgmt_read && (i_mgmt_address == `ADDR_NEG_STAT);

////////////////////////////////////////////////////////////////////////////////
// Sequencer control register
reg        neg_tmo_q;
reg        page_arrived_q;
reg        inject_q;

always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_seq_restart        <= 1'b0;
        o_fec_ability        <= 1'b0;
        o_fec_error_indicate <= 1'b0;
        o_fec_request_flag   <= 1'b0;
    end else begin
        o_seq_restart <= wr_seq_ctrl & i_mgmt_writedata[`SEQ_RESTART_BIT];
        if (wr_seq_ctrl) begin
            o_fec_ability        <= i_mgmt_writedata[`FEC_ABILITY_BIT];
            o_fec_error_indicate <= i_mgmt_writedata[`FEC_ERRIND_BIT];
            o_fec_request_flag   <= i_mgmt_writedata[`FEC_REQUEST_BIT];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Error injection register
always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_transcoder_error_enable <= 1'b0;
        o_encoder_burst_enable    <= 1'b0;
        o_error_burst_length      <= 4'h0;
        o_error_inject_pulse      <= 1'b0;
        inject_q                  <= 1'b0;
    end else begin
        if (wr_fec_inj) begin
            inject_q <= i_mgmt_writedata[`INJECT_BIT];
        end
        if (wr_fec_inj) begin
            o_transcoder_error_enable <= i_mgmt_writedata[`TRANS_EN_BIT];
            o_encoder_burst_enable    <= i_mgmt_writedata[`BURST_EN_BIT];
            o_error_burst_length      <=
                i_mgmt_writedata[`BURST_LEN_MSB:`BURST_LEN_LSB];
        end
        // Pulse on a write of one while an injection enable is already set, stored bit kept for software to clear
        o_error_inject_pulse <= wr_fec_inj & i_mgmt_writedata[`INJECT_BIT] &
                                (o_transcoder_error_enable | o_encoder_burst_enable);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Negotiation control register
always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_neg_enable                  <= 1'b1;
        o_user_base_page_select       <= 1'b0;
        o_user_next_page_select       <= 1'b0;
        o_force_nonce                 <= 1'b0;
        o_negotiation_override_enable <= 1'b0;
    end else begin
        if (wr_neg_ctrl) begin
            o_neg_enable                  <= i_mgmt_writedata[`NEG_EN_BIT];
            o_user_base_page_select       <= i_mgmt_writedata[`USER_BASE_BIT];
            o_user_next_page_select       <= i_mgmt_writedata[`USER_NEXT_BIT];
            o_force_nonce                 <= i_mgmt_writedata[`FORCE_NONCE_BIT];
            o_negotiation_override_enable <= i_mgmt_writedata[`OVERRIDE_BIT];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Negotiation command register
always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_negotiation_reset      <= 1'b0;
        o_negotiation_tx_restart <= 1'b0;
        o_next_page_ready        <= 1'b0;
    end else begin
        o_negotiation_reset <= wr_neg_cmd & i_mgmt_writedata[`NEG_RESET_BIT];
        o_negotiation_tx_restart <= wr_neg_cmd & i_mgmt_writedata[`TX_RESTART_BIT] &
                                    in_an_s;
        if (wr_neg_cmd && i_mgmt_writedata[`NEXT_READY_BIT])
            o_next_page_ready <= 1'b1;
        else if (i_next_page_taken || o_negotiation_reset)
            o_next_page_ready <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status flags and page edge detect
always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        neg_tmo_q      <= 1'b0;
        page_arrived_q <= 1'b0;
        page_prev_q    <= 1'b0;
    end else begin
        page_prev_q <= page_lvl_s;
        if (neg_tmo_s)
            neg_tmo_q <= 1'b1;
        else if (neg_rst_s)
            neg_tmo_q <= 1'b0;
        if (page_ev)
            page_arrived_q <= 1'b1;
        else if (rd_neg_stat)
            page_arrived_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Block counters
wire [31:0] corr_count;
wire [31:0] uncorr_count;

sat_event_counter u_corr_count (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_event   (corr_ev),
    .i_clear   (rd_corr),
    .o_count   (corr_count)
);

sat_event_counter u_uncorr_count (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_event   (uncorr_ev),
    .i_clear   (rd_uncorr),
    .o_count   (uncorr_count)
);

////////////////////////////////////////////////////////////////////////////////
// Read mux
reg [31:0] rd_d;
always @* begin
    rd_d = 32'h0000_0000;
    case (i_mgmt_address)
        `ADDR_SEQ_CTRL: begin
            rd_d[`FEC_ABILITY_BIT] = o_fec_ability;
            rd_d[`FEC_ERRIND_BIT]  = o_fec_error_indicate;
            rd_d[`FEC_REQUEST_BIT] = o_fec_request_flag;
        end
        `ADDR_SEQ_STAT: begin
            rd_d[`LINK_READY_BIT]          = link_ready_s;
            rd_d[`NEG_TIMEOUT_BIT]         = neg_tmo_q;
            rd_d[`TRN_TIMEOUT_BIT]         = trn_tmo_s;
            rd_d[`MODE_MSB:`MODE_LSB]      = mode_s;
            rd_d[`CAP_FEC_BIT]             = fec_sup_s;
            rd_d[`CAP_ERRIND_BIT]          = errind_sup_s;
        end
        `ADDR_FEC_INJ: begin
            rd_d[`TRANS_EN_BIT]                = o_transcoder_error_enable;
            rd_d[`BURST_EN_BIT]                = o_encoder_burst_enable;
            rd_d[`BURST_LEN_MSB:`BURST_LEN_LSB] = o_error_burst_length;
            rd_d[`INJECT_BIT]                  = inject_q;
        end
        `ADDR_FEC_CORR: begin
            rd_d = corr_count;
        end
        `ADDR_FEC_UNCORR: begin
            rd_d = uncorr_count;
        end
        `ADDR_NEG_CTRL: begin
            rd_d[`NEG_EN_BIT]      = o_neg_enable;
            rd_d[`USER_BASE_BIT]   = o_user_base_page_select;
            rd_d[`USER_NEXT_BIT]   = o_user_next_page_select;
            rd_d[`LOCAL_RF_BIT]    = local_rf_s;
            rd_d[`FORCE_NONCE_BIT] = o_force_nonce;
            rd_d[`OVERRIDE_BIT]    = o_negotiation_override_enable;
        end
        `ADDR_NEG_CMD: begin
            rd_d[`NEXT_READY_BIT] = o_next_page_ready;
        end
        `ADDR_NEG_STAT: begin
            rd_d[`PAGE_ARRIVED_BIT] = page_arrived_q;
            rd_d[`NEG_DONE_BIT]     = neg_done_s;
        end
        default: rd_d = 32'h0000_0000;
    endcase
end

always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_mgmt_readdata      <= 32'h0000_0000;
        o_mgmt_readdatavalid <= 1'b0;
    end else begin
        o_mgmt_readdatavalid <= i_mgmt_read;
        if (i_mgmt_read)
            o_mgmt_readdata <= rd_d;
    end
end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser
module sync_2ff #(
    parameter WIDTH = 1
) (
    input  wire             i_sys_clk,
    input  wire             i_reset_n,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);

reg [WIDTH-1:0] meta_q;

always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        meta_q <= {WIDTH{1'b0}};
        o_sync <= {WIDTH{1'b0}};
    end else begin
        meta_q <= i_async;
        o_sync <= meta_q;
    end
end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Saturating event counter, cleared on read
module sat_event_counter (
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    input  wire        i_event,
    input  wire        i_clear,
    output reg  [31:0] o_count
);

// Event in the clear cycle is kept, never lost
always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_count <= 32'h0000_0000;
    end else if (i_clear) begin
        o_count <= {31'h0000_0000, i_event};
    end else if (i_event && o_count != `COUNT_MAX) begin
        o_count <= o_count + 32'h0000_0001;
    end
end

endmodule

// *** rtl/kr_csr_defs.vh ***
`ifndef KR_CSR_DEFS_VH
`define KR_CSR_DEFS_VH
// Word addresses
`define ADDR_SEQ_CTRL      8'hb0
`define ADDR_SEQ_STAT      8'hb1
`define ADDR_FEC_INJ       8'hb2
`define ADDR_FEC_CORR      8'hb3
`define ADDR_FEC_UNCORR    8'hb4
`define ADDR_NEG_CTRL      8'hc0
`define ADDR_NEG_CMD       8'hc1
`define ADDR_NEG_STAT      8'hc2
// Sequencer control fields
`define SEQ_RESTART_BIT    0
`define FEC_ABILITY_BIT    16
`define FEC_ERRIND_BIT     17
`define FEC_REQUEST_BIT    18
// Sequencer status fields
`define LINK_READY_BIT     0
`define NEG_TIMEOUT_BIT    1
`define TRN_TIMEOUT_BIT    2
`define MODE_LSB           8
`define MODE_MSB           13
`define CAP_FEC_BIT        16
`define CAP_ERRIND_BIT     17
// Error injection fields
`define TRANS_EN_BIT       0
`define BURST_EN_BIT       1
`define BURST_LEN_LSB      2
`define BURST_LEN_MSB      5
`define INJECT_BIT         11
// Negotiation control fields
`define NEG_EN_BIT         0
`define USER_BASE_BIT      1
`define USER_NEXT_BIT      2
`define LOCAL_RF_BIT       3
`define FORCE_NONCE_BIT    4
`define OVERRIDE_BIT       5
// Negotiation command fields
`define NEG_RESET_BIT      0
`define TX_RESTART_BIT     4
`define NEXT_READY_BIT     8
// Negotiation status fields
`define PAGE_ARRIVED_BIT   1
`define NEG_DONE_BIT       2
// Reset values and counter limit
`define NEG_CTRL_RESET     6'h01
`define COUNT_MAX          32'hffff_ffff
`endif

// *** test/backplane_phy_seq_fec_an_csr_tb.sv ***
`timescale 1ns/1ns
module backplane_phy_seq_fec_an_csr_tb;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic        rd_s    = 1'b0;
    logic        wr_s    = 1'b0;
    logic [31:0] wd      = 32'h0000_0000;
    logic [31:0] rdata, q;
    // Status inputs: link, timeout, restart, trn, fec, errind, corr, uncorr,
    // in-an, fault, page, done
    logic [11:0] st      = 12'h211;
    logic [5:0]  mode    = 6'h04;
    logic [2:0]  dly     = 3'h0;
    logic        taken, seq_rst, neg_rst, txr, npr;
    logic [71:0] rows [0:7];
    int          n_mismatch = 0;
    int          compares   = 0;
    always #4 sys_clk = ~sys_clk;
    backplane_phy_seq_fec_an_csr dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_mgmt_address(addr), .i_mgmt_read(rd_s), .i_mgmt_write(wr_s),
        .i_mgmt_writedata(wd), .o_mgmt_readdata(rdata), .o_mgmt_readdatavalid(),
        .i_seq_link_ready(st[0]), .i_seq_neg_timeout(st[1]), .i_seq_neg_restart(st[2]),
        .i_seq_trn_timeout(st[3]), .i_seq_mode(mode), .o_seq_restart(seq_rst),
        .o_fec_ability(), .o_fec_error_indicate(), .o_fec_request_flag(),
        .i_fec_supported(st[4]), .i_fec_errind_supported(st[5]), .i_fec_corrected(st[6]),
        .i_fec_uncorrectable(st[7]), .o_transcoder_error_enable(), .o_encoder_burst_enable(),
        .o_error_burst_length(), .o_error_inject_pulse(), .i_neg_tx_in_an_state(st[8]),
        .i_neg_local_fault(st[9]), .i_neg_page_arrived(st[10]), .i_neg_done(st[11]),
        .i_next_page_taken(taken), .o_neg_enable(), .o_user_base_page_select(),
        .o_user_next_page_select(), .o_force_nonce(), .o_negotiation_override_enable(),
        .o_negotiation_reset(neg_rst), .o_negotiation_tx_restart(txr), .o_next_page_ready(npr));
    np_partner_model u_partner (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_delay(dly),
        .i_next_page_ready(npr), .o_next_page_taken(taken));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        @(posedge sys_clk);
        #1 v = rdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp=%h got=%h", nm, exp, got);
        end
    endtask
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            st[b] <= 1'b1;
            repeat (2) @(posedge sys_clk);
            st[b] <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{{8'hc0, 32'h0000_0037, 32'h0000_003f}, {8'hc0, 32'h0000_0000, 32'h0000_0008},
            {8'hb2, 32'h0000_083f, 32'h0000_083f}, {8'hb2, 32'h0000_0835, 32'h0000_0835},
            {8'hb2, 32'h0000_0000, 32'h0000_0000}, {8'hb0, 32'h0007_0000, 32'h0007_0000},
            {8'hb1, 32'hffff_ffff, 32'h0001_0401}, {8'h50, 32'hffff_ffff, 32'h0000_0000}};
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i][71:64], rows[i][63:32]);
            rd(rows[i][71:64], q);
            chk("row", q, rows[i][31:0]);
        end
        $display("test rows done");
        wr(8'hb0, 32'h0007_0001);
        #1 chk("req_restart", seq_rst, 1);
        wr(8'hb0, 32'h0000_0001);
        #1 chk("seq_restart", seq_rst, 1);
        wr(8'hc1, 32'h0000_0001);
        #1 chk("neg_reset", neg_rst, 1);
        wr(8'hc1, 32'h0000_0010);
        #1 chk("tx_restart_off", txr, 0);
        st[8] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wr(8'hc1, 32'h0000_0010);
        #1 chk("tx_restart_on", txr, 1);
        for (int d = 0; d < 6; d += 5) begin
            dly <= 3'(d);
            wr(8'hc1, 32'h0000_0100);
            #1 chk("np_ready_set", npr, 1);
            repeat (10) @(posedge sys_clk);
            chk("np_ready_clear", npr, 0);
        end
        $display("test pulses done");
        pulse(6, 3);
        pulse(7, 2);
        pulse(1, 1);
        pulse(10, 1);
        st[11] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(8'hb3, q);
        chk("corrected", q, 3);
        rd(8'hb3, q);
        chk("corrected_clr", q, 0);
        rd(8'hb4, q);
        chk("uncorrectable", q, 2);
        rd(8'hb4, q);
        chk("uncorrectable_clr", q, 0);
        rd(8'hb1, q);
        chk("neg_timeout", q[1], 1);
        pulse(2, 1);
        rd(8'hb1, q);
        chk("neg_timeout_clr", q[1], 0);
        rd(8'hc2, q);
        chk("page_done", q[2:1], 3);
        rd(8'hc2, q);
        chk("page_clr", q[2:1], 2);
        $display("test status done");
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(8'hc0, q);
        chk("neg_ctrl_reset", q, 32'h0000_0009);
        $display("test reset done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end
endmodule

// *** test/csr_props.sv ***
`timescale 1ns/1ns
module csr_props (
    input logic        i_sys_clk,
    input logic        i_reset_n,
    input logic [7:0]  i_mgmt_address,
    input logic        i_mgmt_write,
    input logic [31:0] i_mgmt_writedata,
    input logic        o_seq_restart,
    input logic        o_negotiation_reset,
    input logic        o_negotiation_tx_restart,
    input logic        o_error_inject_pulse,
    input logic        o_transcoder_error_enable,
    input logic        o_encoder_burst_enable,
    input logic [3:0]  o_error_burst_length,
    input logic        o_neg_enable,
    input logic        o_force_nonce,
    input logic        o_next_page_ready
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////////////////////////////////////
    sequence s_wa(a);
        i_mgmt_write && i_mgmt_address == a;
    endsequence
    sequence s_wb(a, b);
        i_mgmt_write && i_mgmt_address == a && i_mgmt_writedata[b];
    endsequence
    sequence s_pulse(s);
        s ##1 !s;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_SEQ_RESTART: assert property (s_wb(8'hb0, 0) |=> s_pulse(o_seq_restart))
        else $error("restart pulse wrong");
    AST_RESTART_CAUSE: assert property (o_seq_restart |-> $past(i_mgmt_write &&
        i_mgmt_address == 8'hb0 && i_mgmt_writedata[0])) else $error("stray restart");
    AST_NEG_RESET: assert property (s_wb(8'hc1, 0) |=> s_pulse(o_negotiation_reset))
        else $error("negotiation reset pulse wrong");
    AST_TX_RESTART: assert property (o_negotiation_tx_restart |-> $past(i_mgmt_write &&
        i_mgmt_address == 8'hc1 && i_mgmt_writedata[4])) else $error("stray tx restart");
    AST_INJECT: assert property (o_error_inject_pulse |-> $past(i_mgmt_write &&
        i_mgmt_address == 8'hb2 && i_mgmt_writedata[11] &&
        (o_transcoder_error_enable || o_encoder_burst_enable))) else $error("stray inject");
    AST_INJ_ENABLES: assert property (s_wa(8'hb2) |=>
        {o_encoder_burst_enable, o_transcoder_error_enable} == $past(i_mgmt_writedata[1:0]))
        else $error("injection enables wrong");
    AST_BURST_LEN: assert property (s_wa(8'hb2) |=>
        o_error_burst_length == $past(i_mgmt_writedata[5:2])) else $error("burst length wrong");
    AST_NEG_CTRL: assert property (s_wa(8'hc0) |=> o_neg_enable == $past(i_mgmt_writedata[0])
        && o_force_nonce == $past(i_mgmt_writedata[4])) else $error("negotiation control wrong");
    AST_NP_READY: assert property (s_wb(8'hc1, 8) |=> o_next_page_ready)
        else $error("next page ready not set");
endmodule
bind backplane_phy_seq_fec_an_csr csr_props u_props (.i_sys_clk, .i_reset_n, .i_mgmt_address,
    .i_mgmt_write, .i_mgmt_writedata, .o_seq_restart, .o_negotiation_reset,
    .o_negotiation_tx_restart, .o_error_inject_pulse, .o_transcoder_error_enable,
    .o_encoder_burst_enable, .o_error_burst_length, .o_neg_enable, .o_force_nonce,
    .o_next_page_ready);

// *** test/np_partner_model.sv ***
`timescale 1ns/1ns
// Takes a next page some cycles after it is offered
module np_partner_model (
    input  logic       i_sys_clk,
    input  logic       i_reset_n,
    input  logic [2:0] i_delay,
    input  logic       i_next_page_ready,
    output logic       o_next_page_taken
);
    logic [2:0] wait_q;
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_q <= 3'h0;
            o_next_page_taken <= 1'b0;
        end else begin
            o_next_page_taken <= 1'b0;
            if (i_next_page_ready && !o_next_page_taken) begin
                wait_q <= wait_q + 3'h1;
                if (wait_q == i_delay) begin
                    wait_q <= 3'h0;
                    o_next_page_taken <= 1'b1;
                end
            end
        end
    end
endmodule
